/* design/gdr_map.svh */
`ifndef GDR_MAP_SVH
`define GDR_MAP_SVH

// Timebase
`define GDR_CLK_PERIOD_NS 8
`define GDR_TICK_NS 1000000
`define GDR_TICK_CYCLES (`GDR_TICK_NS / `GDR_CLK_PERIOD_NS)

// Supervisor register offsets
`define GDR_QV_CTRL_OFS 8'h00
`define GDR_QV_MIN_I_OFS 8'h04
`define GDR_QV_Q_THR_OFS 8'h08
`define GDR_QV_TAN_OFS 8'h0C
`define GDR_QV_NOM_OFS 8'h10
`define GDR_QV_GEN_MS_OFS 8'h14
`define GDR_QV_PCC_MS_OFS 8'h18
`define GDR_QV_STATUS_OFS 8'h1C

// Reconnection register block, one per instance
`define GDR_RC_BASE_IDX 3'h2
`define GDR_RC_CTRL_OFS 5'h00
`define GDR_RC_VRANGE_OFS 5'h04
`define GDR_RC_FRANGE_OFS 5'h08
`define GDR_RC_SETTLE_OFS 5'h0C
`define GDR_RC_STATUS_OFS 5'h10

// Supervisor control fields
`define GDR_QV_EN_BIT 0
`define GDR_DECOUPLING_METHOD_SELECT_BIT 1
`define GDR_QV_MIN_EN_BIT 2

// Reconnection control fields
`define GDR_RC_MASK_HI 5
`define GDR_RC_COND_LO 6
`define GDR_RC_COND_HI 7
`define GDR_RC_AVG_BIT 8
`define GDR_RC_RECONNECTION_INSTANCE_EN_BIT 9

// Reset values
`define GDR_QV_CTRL_RST 3'h0
`define GDR_QV_MIN_I_RST 16'h0000
`define GDR_QV_Q_THR_RST 24'h00_0000
`define GDR_QV_TAN_RST 16'h0000
`define GDR_QV_NOM_RST 16'h0190
`define GDR_STAGE_MS_RST 16'h01F4
`define GDR_RC_CTRL_RST 10'h000
`define GDR_RC_RANGE_RST 32'hFFFF_0000
`define GDR_RC_SETTLE_RST 16'h0000

// Undervoltage ratio, numerator over denominator
`define GDR_UV_NUM 24'h00_0055
`define GDR_UV_DEN 24'h00_0064

`endif

/* design/gdr_pkg.sv */
package gdr_pkg;

  typedef enum logic [0:0] {
    GDR_METHOD_ANGLE = 1'h0,
    GDR_METHOD_PURE_Q = 1'h1
  } gdr_method_t;

  typedef enum logic [1:0] {
    GDR_COND_INTERNAL = 2'h0,
    GDR_COND_EXTERNAL = 2'h1,
    GDR_COND_BOTH = 2'h2
  } gdr_cond_t;

  typedef enum logic [2:0] {
    GDR_RC_SETTLE = 3'h1,
    GDR_RC_RELEASE = 3'h2,
    GDR_RC_DONE = 3'h4
  } gdr_rc_state_t;

endpackage

/* design/gdr_stage_timer.sv */
`timescale 1ns/1ps
module gdr_stage_timer (
  // Clock and timebase
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  // Control
  input wire logic start_in,
  input wire logic [15:0] limit_ms,
  // Result
  output logic done_out
);
  logic [15:0] count_reg;
  wire [15:0] count_next = !start_in ? 16'h0000 :
                           (tick && count_reg < limit_ms) ? count_reg + 16'h0001 : count_reg;
  wire done_next = start_in && (count_next >= limit_ms);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_reg <= 16'h0000;
      done_out <= 1'b0;
    end else begin
      count_reg <= count_next;
      done_out <= done_next;
    end
  end
endmodule

/* design/gdr_reconnection_instance.sv */
`timescale 1ns/1ps
`include "gdr_map.svh"
module gdr_reconnection_instance
  import gdr_pkg::*;
(
  // Clock and timebase
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  // Triggers and qualifiers
  input wire logic [5:0] decouple_trig,
  input wire logic ext_trig,
  input wire logic block_in,
  input wire logic reconnected_in,
  input wire logic external_coupling_release,
  // Measurements
  input wire logic [47:0] v_ll,
  input wire logic [47:0] v_avg,
  input wire logic [15:0] freq,
  // Settings
  input wire logic [9:0] ctrl,
  input wire logic [31:0] voltage_release_range,
  input wire logic [31:0] freq_range,
  input wire logic [15:0] settle_ms,
  // Results
  output logic release_output,
  output logic [15:0] settle_count
);
  gdr_rc_state_t state_reg;
  gdr_rc_state_t state_next;
  logic [2:0] v_in_range;
  wire use_avg = ctrl[`GDR_RC_AVG_BIT];

  // Voltage window per line-to-line value
  for (genvar i = 0; i < 3; i++) begin : g_ph
    wire [15:0] v_sel = use_avg ? v_avg[16*i +: 16] : v_ll[16*i +: 16];
    assign v_in_range[i] = (v_sel >= voltage_release_range[15:0]) && (v_sel <= voltage_release_range[31:16]);
  end

  wire v_ok = &v_in_range;
  wire f_ok = (freq >= freq_range[15:0]) && (freq <= freq_range[31:16]);
  wire [1:0] cond = ctrl[`GDR_RC_COND_HI:`GDR_RC_COND_LO];
  wire trig_any = (|(decouple_trig & ctrl[`GDR_RC_MASK_HI:0])) || ext_trig;
  wire volt_pass = (cond == GDR_COND_INTERNAL) ? v_ok :
                   (cond == GDR_COND_EXTERNAL) ? external_coupling_release :
                   (v_ok && external_coupling_release);
  wire qual = f_ok && volt_pass;
  wire [15:0] cnt_next = (!qual || trig_any) ? 16'h0000 :
                         (tick && settle_count < settle_ms) ? settle_count + 16'h0001 : settle_count;
  wire settled = qual && (settle_count >= settle_ms);
  wire reconnection_instance_done = reconnected_in && ctrl[`GDR_RC_RECONNECTION_INSTANCE_EN_BIT];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      GDR_RC_SETTLE: begin
        if (settled && !trig_any && !block_in) begin
          state_next = GDR_RC_RELEASE;
        end
      end
      GDR_RC_RELEASE: begin
        if (trig_any || block_in || !qual) begin
          state_next = GDR_RC_SETTLE;
        end else if (reconnection_instance_done) begin
          state_next = GDR_RC_DONE;
        end
      end
      GDR_RC_DONE: begin
        if (trig_any) begin
          state_next = GDR_RC_SETTLE;
        end
      end
      default: begin
        state_next = GDR_RC_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= GDR_RC_SETTLE;
      settle_count <= 16'h0000;
      release_output <= 1'b0;
    end else begin
      state_reg <= state_next;
      settle_count <= cnt_next;
      release_output <= (state_next == GDR_RC_RELEASE);
    end
  end
endmodule

/* design/gdr_top.sv */
`timescale 1ns/1ps
`include "gdr_map.svh"
module gdr_top
  import gdr_pkg::*;
#(
  parameter int TICK_CYCLES = `GDR_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Measurements
  input wire logic signed [23:0] positive_sequence_reactive_power,
  input wire logic signed [23:0] positive_sequence_active_power,
  input wire logic [15:0] positive_sequence_current,
  input wire logic [47:0] v_ll_in,
  input wire logic [47:0] v_avg_in,
  input wire logic [15:0] freq_in,
  // Decoupling and reconnection inputs
  input wire logic [3:0] decoupling_in,
  input wire logic [1:0] reconnection_instance_trig_in,
  input wire logic [1:0] reconnection_instance_block_in,
  input wire logic [1:0] reconnected_in,
  input wire logic [1:0] external_coupling_release,
  // Decoupling and release outputs
  output logic gen_stage_trip,
  output logic coupling_point_stage_timer,
  output logic [1:0] release_output
);
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Register file
  logic [2:0] qv_ctrl_reg;
  logic [15:0] min_current_threshold;
  logic [23:0] reactive_power_threshold;
  logic [15:0] tan_reg;
  logic [15:0] nom_reg;
  logic [15:0] gen_ms_reg;
  logic [15:0] pcc_ms_reg;
  logic [9:0] rc_ctrl_reg [0:1];
  logic [31:0] rc_vrange_reg [0:1];
  logic [31:0] rc_frange_reg [0:1];
  logic [15:0] rc_settle_reg [0:1];
  logic [15:0] rc_settle_cnt [0:1];
  logic [1:0] rc_release;
  logic [1:0] rc_trig_any;
  logic [31:0] rc_rd [0:1];
  logic [31:0] div_reg;
  logic tick_reg;
  logic pickup_reg;
  logic gen_done;
  logic pcc_done;

  // Bus handshake: one wait cycle, then accept
  wire bus_req = avs_read || avs_write;
  wire wr_go = avs_write && !avs_waitrequest;
  wire rd_take = avs_read && avs_waitrequest;
  wire rc_hit0 = avs_address[7:5] == `GDR_RC_BASE_IDX;
  wire rc_hit1 = avs_address[7:5] == (`GDR_RC_BASE_IDX + 3'h1);
  wire [4:0] rc_sub = avs_address[4:0];
  wire [31:0] wmask = avs_writedata;

  // Millisecond timebase
  wire tick_wrap = div_reg == 32'(TICK_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= tick_wrap ? 32'h0000_0000 : div_reg + 32'h0000_0001;
      tick_reg <= tick_wrap;
    end
  end

  // Decoupling supervisor
  gdr_method_t decoupling_method_select;
  assign decoupling_method_select = gdr_method_t'(qv_ctrl_reg[`GDR_DECOUPLING_METHOD_SELECT_BIT]);
  wire qv_en = qv_ctrl_reg[`GDR_QV_EN_BIT];
  wire min_en = qv_ctrl_reg[`GDR_QV_MIN_EN_BIT];
  logic [2:0] uv_ph;
  wire [23:0] uv_limit = {8'h00, nom_reg} * `GDR_UV_NUM;
  for (genvar i = 0; i < 3; i++) begin : g_uv
    wire [23:0] v_scaled = {8'h00, v_ll_in[16*i +: 16]} * `GDR_UV_DEN;
    assign uv_ph[i] = v_scaled < uv_limit;
  end
  wire uv_all = &uv_ph;

  wire signed [23:0] q_pos = positive_sequence_reactive_power;
  wire signed [23:0] p1 = positive_sequence_active_power;
  wire cur_ok = positive_sequence_current >= min_current_threshold;
  wire q_consumed = q_pos > 24'sh00_0000;
  wire [23:0] p_abs = p1[23] ? 24'(-p1) : 24'(p1);
  wire [39:0] angle_limit = {16'h0000, p_abs} * {24'h00_0000, tan_reg};
  wire [39:0] q_scaled = {9'h000, q_pos[22:0], 8'h00};
  wire angle_hit = q_consumed && (q_scaled >= angle_limit);
  wire pure_hit = q_pos > $signed({1'b0, reactive_power_threshold[22:0]});
  wire q_detect = (decoupling_method_select == GDR_METHOD_ANGLE) ? (angle_hit && cur_ok) :
                  (pure_hit && (cur_ok || !min_en));
  wire pickup_next = qv_en && uv_all && q_detect;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pickup_reg <= 1'b0;
    end else begin
      pickup_reg <= pickup_next;
    end
  end

  // Both stages share the pick-up as start
  gdr_stage_timer u_gen_stage (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick_reg),
    .start_in(pickup_reg),
    .limit_ms(gen_ms_reg),
    .done_out(gen_done)
  );

  gdr_stage_timer u_pcc_stage (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick_reg),
    .start_in(pickup_reg),
    .limit_ms(pcc_ms_reg),
    .done_out(pcc_done)
  );

  assign gen_stage_trip = gen_done;
  assign coupling_point_stage_timer = pcc_done;
  assign release_output = rc_release;

  wire [5:0] decouple_vec = {decoupling_in, pcc_done, gen_done};

  // Reconnection instances and their registers
  for (genvar n = 0; n < 2; n++) begin : g_rc
    wire hit = (n == 0) ? rc_hit0 : rc_hit1;
    wire wr_ctrl = wr_go && hit && rc_sub == `GDR_RC_CTRL_OFS;
    wire wr_vr = wr_go && hit && rc_sub == `GDR_RC_VRANGE_OFS;
    wire wr_fr = wr_go && hit && rc_sub == `GDR_RC_FRANGE_OFS;
    wire wr_st = wr_go && hit && rc_sub == `GDR_RC_SETTLE_OFS;
    wire [31:0] ctrl_m = be_merge({22'h00_0000, rc_ctrl_reg[n]}, wmask, avs_byteenable);
    wire [31:0] st_m = be_merge({16'h0000, rc_settle_reg[n]}, wmask, avs_byteenable);

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        rc_ctrl_reg[n] <= `GDR_RC_CTRL_RST;
        rc_vrange_reg[n] <= `GDR_RC_RANGE_RST;
        rc_frange_reg[n] <= `GDR_RC_RANGE_RST;
        rc_settle_reg[n] <= `GDR_RC_SETTLE_RST;
      end else begin
        if (wr_ctrl) rc_ctrl_reg[n] <= ctrl_m[9:0];
        if (wr_vr) rc_vrange_reg[n] <= be_merge(rc_vrange_reg[n], wmask, avs_byteenable);
        if (wr_fr) rc_frange_reg[n] <= be_merge(rc_frange_reg[n], wmask, avs_byteenable);
        if (wr_st) rc_settle_reg[n] <= st_m[15:0];
      end
    end

    assign rc_trig_any[n] = (|(decouple_vec & rc_ctrl_reg[n][`GDR_RC_MASK_HI:0])) || reconnection_instance_trig_in[n];
    assign rc_rd[n] = (rc_sub == `GDR_RC_CTRL_OFS) ? {22'h00_0000, rc_ctrl_reg[n]} :
                      (rc_sub == `GDR_RC_VRANGE_OFS) ? rc_vrange_reg[n] :
                      (rc_sub == `GDR_RC_FRANGE_OFS) ? rc_frange_reg[n] :
                      (rc_sub == `GDR_RC_SETTLE_OFS) ? {16'h0000, rc_settle_reg[n]} :
                      (rc_sub == `GDR_RC_STATUS_OFS) ? {15'h0000, rc_release[n], rc_settle_cnt[n]} :
                      32'h0000_0000;

    gdr_reconnection_instance u_reconnection_instance (
      .clk(clk),
      .reset_n(reset_n),
      .tick(tick_reg),
      .decouple_trig(decouple_vec),
      .ext_trig(reconnection_instance_trig_in[n]),
      .block_in(reconnection_instance_block_in[n]),
      .reconnected_in(reconnected_in[n]),
      .external_coupling_release(external_coupling_release[n]),
      .v_ll(v_ll_in),
      .v_avg(v_avg_in),
      .freq(freq_in),
      .ctrl(rc_ctrl_reg[n]),
      .voltage_release_range(rc_vrange_reg[n]),
      .freq_range(rc_frange_reg[n]),
      .settle_ms(rc_settle_reg[n]),
      .release_output(rc_release[n]),
      .settle_count(rc_settle_cnt[n])
    );
  end

  // Supervisor registers
  wire [31:0] ctrl_mg = be_merge({29'h0000_0000, qv_ctrl_reg}, wmask, avs_byteenable);
  wire [31:0] mini_mg = be_merge({16'h0000, min_current_threshold}, wmask, avs_byteenable);
  wire [31:0] qthr_mg = be_merge({8'h00, reactive_power_threshold}, wmask, avs_byteenable);
  wire [31:0] tan_mg = be_merge({16'h0000, tan_reg}, wmask, avs_byteenable);
  wire [31:0] nom_mg = be_merge({16'h0000, nom_reg}, wmask, avs_byteenable);
  wire [31:0] gen_mg = be_merge({16'h0000, gen_ms_reg}, wmask, avs_byteenable);
  wire [31:0] pcc_mg = be_merge({16'h0000, pcc_ms_reg}, wmask, avs_byteenable);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      qv_ctrl_reg <= `GDR_QV_CTRL_RST;
      min_current_threshold <= `GDR_QV_MIN_I_RST;
      reactive_power_threshold <= `GDR_QV_Q_THR_RST;
      tan_reg <= `GDR_QV_TAN_RST;
      nom_reg <= `GDR_QV_NOM_RST;
      gen_ms_reg <= `GDR_STAGE_MS_RST;
      pcc_ms_reg <= `GDR_STAGE_MS_RST;
    end else if (wr_go) begin
      if (avs_address == `GDR_QV_CTRL_OFS) qv_ctrl_reg <= ctrl_mg[2:0];
      if (avs_address == `GDR_QV_MIN_I_OFS) min_current_threshold <= mini_mg[15:0];
      if (avs_address == `GDR_QV_Q_THR_OFS) reactive_power_threshold <= qthr_mg[23:0];
      if (avs_address == `GDR_QV_TAN_OFS) tan_reg <= tan_mg[15:0];
      if (avs_address == `GDR_QV_NOM_OFS) nom_reg <= nom_mg[15:0];
      if (avs_address == `GDR_QV_GEN_MS_OFS) gen_ms_reg <= gen_mg[15:0];
      if (avs_address == `GDR_QV_PCC_MS_OFS) pcc_ms_reg <= pcc_mg[15:0];
    end
  end

  // Read selection
  wire [31:0] qv_status = {25'h000_0000, rc_release, pcc_done, gen_done, pickup_reg, q_detect, uv_all};
  wire [31:0] rd_mux = (avs_address == `GDR_QV_CTRL_OFS) ? {29'h0000_0000, qv_ctrl_reg} :
                       (avs_address == `GDR_QV_MIN_I_OFS) ? {16'h0000, min_current_threshold} :
                       (avs_address == `GDR_QV_Q_THR_OFS) ? {8'h00, reactive_power_threshold} :
                       (avs_address == `GDR_QV_TAN_OFS) ? {16'h0000, tan_reg} :
                       (avs_address == `GDR_QV_NOM_OFS) ? {16'h0000, nom_reg} :
                       (avs_address == `GDR_QV_GEN_MS_OFS) ? {16'h0000, gen_ms_reg} :
                       (avs_address == `GDR_QV_PCC_MS_OFS) ? {16'h0000, pcc_ms_reg} :
                       (avs_address == `GDR_QV_STATUS_OFS) ? qv_status :
                       rc_hit0 ? rc_rd[0] :
                       rc_hit1 ? rc_rd[1] :
                       32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
      if (rd_take) avs_readdata <= rd_mux;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence bus_req_s;
    bus_req && avs_waitrequest;
  endsequence

  sequence bus_ack_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  bus_answer_a: assert property (bus_req_s |=> bus_ack_s)
    else $error("Bus request not answered after one wait cycle");
  uv_all_phases_a: assert property (pickup_reg |-> $past(qv_en && uv_ph == 3'h7))
    else $error("Pick-up without all three line voltages low");
  angle_current_a: assert property (pickup_reg && $past(decoupling_method_select == GDR_METHOD_ANGLE)
                                    |-> $past(cur_ok && q_pos > 24'sh00_0000))
    else $error("Angle method picked up below minimum current");
  pure_q_a: assert property (pickup_reg && $past(decoupling_method_select == GDR_METHOD_PURE_Q)
                             |-> $past(pure_hit && (cur_ok || !min_en)))
    else $error("Pure reactive method picked up without threshold");
  low_current_a: assert property ($past(min_en || decoupling_method_select == GDR_METHOD_ANGLE)
                                  && $past(!cur_ok) |-> !pickup_reg)
    else $error("Detection not suppressed at low current");
  stages_follow_a: assert property (!pickup_reg |=> !gen_done && !pcc_done)
    else $error("Stage timer active without pick-up");

  for (genvar n = 0; n < 2; n++) begin : g_chk
    release_block_a: assert property (reconnection_instance_block_in[n] |=> !rc_release[n])
      else $error("Release asserted while blocked");
    release_trig_a: assert property (rc_trig_any[n] |=> !rc_release[n])
      else $error("Release asserted with decoupling trigger active");
    release_settle_a: assert property ($rose(rc_release[n]) |-> $past(rc_settle_cnt[n] >= rc_settle_reg[n]))
      else $error("Release before settle time elapsed");
    release_drop_a: assert property (rc_release[n] && reconnected_in[n] && rc_ctrl_reg[n][`GDR_RC_RECONNECTION_INSTANCE_EN_BIT]
                                     |=> !rc_release[n])
      else $error("Release held after reconnection reported");
  end
endmodule

/* verification/gdr_front_end.sv */
`timescale 1ns/1ps
module gdr_front_end (
  // Measurements towards the block
  output logic signed [23:0] q_pos,
  output logic signed [23:0] p_pos,
  output logic [15:0] i_pos,
  output logic [47:0] v_ll,
  output logic [47:0] v_avg,
  output logic [15:0] freq
);
  // Levels change only when the bench calls set_meas just after a clock edge
  initial begin
    q_pos = 24'sh00_0000;
    p_pos = 24'sh00_0000;
    i_pos = 16'h0000;
    v_ll = {3{16'h0180}};
    v_avg = {3{16'h0180}};
    freq = 16'h1388;
  end
  task automatic set_meas(input logic signed [23:0] q, input logic signed [23:0] p, input logic [15:0] i,
                          input logic [47:0] v, input logic [47:0] a, input logic [15:0] f);
    q_pos <= q;
    p_pos <= p;
    i_pos <= i;
    v_ll <= v;
    v_avg <= a;
    freq <= f;
  endtask
endmodule

/* verification/gdr_top_test.sv */
`timescale 1ns/1ps
module gdr_top_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic signed [23:0] q_pos, p_pos;
  logic [15:0] i_pos, freq;
  logic [47:0] v_ll, v_avg;
  logic [3:0] decoupling_in = 4'h0;
  logic [1:0] trig = 2'h0, blk = 2'h0, recd = 2'h0, ext = 2'h0, release_output;
  logic gen_stage_trip, coupling_point_stage_timer;
  logic [31:0] rd;
  int err_count = 0, num_checks = 0, cyc = 0, n, k, m, q, p, ii, mth, mine;
  logic [47:0] v;
  wire logic [3:0] obs = {release_output, coupling_point_stage_timer, gen_stage_trip};
  localparam logic [47:0] VN = {3{16'h0180}};
  localparam logic [47:0] VLO = {3{16'h00C8}};
  gdr_top #(.TICK_CYCLES(10)) i_gdr_top (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .positive_sequence_reactive_power(q_pos), .positive_sequence_active_power(p_pos),
    .positive_sequence_current(i_pos), .v_ll_in(v_ll), .v_avg_in(v_avg), .freq_in(freq),
    .decoupling_in(decoupling_in), .reconnection_instance_trig_in(trig), .reconnection_instance_block_in(blk), .reconnected_in(recd),
    .external_coupling_release(ext), .gen_stage_trip(gen_stage_trip),
    .coupling_point_stage_timer(coupling_point_stage_timer), .release_output(release_output));
  gdr_front_end i_gdr_front_end (.q_pos(q_pos), .p_pos(p_pos), .i_pos(i_pos), .v_ll(v_ll), .v_avg(v_avg),
    .freq(freq));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_for(input int sel, input logic val, input int lim);
    n = 0;
    while (obs[sel] !== val && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("wait", {31'h0, val}, {31'h0, obs[sel]});
  endtask
  task automatic hold_low(input int sel, input int len);
    repeat (len) begin
      @(posedge clk);
      if (obs[sel] !== 1'b0) chk("held low", 32'h0, {31'h0, obs[sel]});
    end
  endtask
  function automatic int q_exp(int q, int p, int i, int mth, int mine);
    if (mth == 0) return int'(q > 0 && q * 256 >= (p < 0 ? -p : p) * 256 && i >= 100);
    return int'(q > 1000 && (mine == 0 || i >= 100));
  endfunction
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    void'($urandom(32'h829c1de5));
    bus(0, 8'h10, 0); chk("nominal", 32'h0000_0190, rd);
    bus(0, 8'h14, 0); chk("gen ms", 32'h0000_01F4, rd);
    bus(0, 8'h44, 0); chk("vrange", 32'hFFFF_0000, rd);
    bus(0, 8'hFC, 0); chk("unmapped", 32'h0, rd);
    bus(1, 8'h04, 100);
    bus(1, 8'h08, 1000);
    bus(1, 8'h0C, 256);
    for (k = 0; k < 24; k++) begin
      q = int'($urandom % 3000) - 1000;
      p = int'($urandom % 3000) - 1500;
      ii = ($urandom % 2) ? 50 : 200;
      mth = $urandom % 2;
      mine = $urandom % 2;
      m = $urandom % 8;
      v = {m[2] ? 16'd300 : 16'd380, m[1] ? 16'd300 : 16'd380, m[0] ? 16'd300 : 16'd380};
      i_gdr_front_end.set_meas(q, p, ii, v, v, 16'h1388);
      bus(1, 8'h00, {29'h0, mine[0], mth[0], 1'b1});
      bus(0, 8'h1C, 0);
      chk("uv", {31'h0, m == 7}, {31'h0, rd[0]});
      chk("q detect", q_exp(q, p, ii, mth, mine), {31'h0, rd[1]});
      chk("pickup", {31'h0, m == 7 && q_exp(q, p, ii, mth, mine) == 1}, {31'h0, rd[2]});
    end
    i_gdr_front_end.set_meas(0, 0, 200, VN, VN, 16'h1388);
    bus(1, 8'h00, 32'h0000_0001);
    bus(1, 8'h14, 2);
    bus(1, 8'h18, 4);
    bus(1, 8'h48, 32'h1400_1300);
    bus(1, 8'h44, 32'h0200_0100);
    bus(1, 8'h4C, 3);
    bus(1, 8'h40, 32'h0000_0041);
    wait_for(2, 1'b0, 5);
    bus(1, 8'h40, 32'h0000_0001);
    wait_for(2, 1'b1, 60);
    i_gdr_front_end.set_meas(500, 0, 200, {VN[47:16], 16'h00C8}, VN, 16'h1388);
    hold_low(0, 100);
    i_gdr_front_end.set_meas(500, 0, 200, VLO, VN, 16'h1388);
    wait_for(0, 1'b1, 40);
    chk("gen delay", 1, {31'h0, n >= 10 && n <= 25});
    chk("pcc early", 0, {31'h0, obs[1]});
    k = n;
    wait_for(1, 1'b1, 40);
    chk("pcc delay", 1, {31'h0, k + n >= 30 && k + n <= 45});
    chk("release on trip", 0, {31'h0, obs[2]});
    i_gdr_front_end.set_meas(0, 0, 200, VN, VN, 16'h1388);
    wait_for(0, 1'b0, 5);
    repeat (15) @(posedge clk);
    i_gdr_front_end.set_meas(0, 0, 200, VN, VN, 16'h1500);
    @(posedge clk);
    bus(0, 8'h50, 0); chk("settle cleared", 0, {16'h0, rd[15:0]});
    i_gdr_front_end.set_meas(0, 0, 200, VN, VN, 16'h1388);
    wait_for(2, 1'b1, 60);
    chk("settle full", 1, {31'h0, n >= 20});
    blk[0] <= 1'b1;
    @(posedge clk);
    wait_for(2, 1'b0, 3); hold_low(2, 40);
    blk[0] <= 1'b0;
    wait_for(2, 1'b1, 60);
    bus(1, 8'h40, 32'h0000_0101);
    i_gdr_front_end.set_meas(0, 0, 200, VN, VLO, 16'h1388);
    wait_for(2, 1'b0, 5);
    bus(1, 8'h40, 32'h0000_0201);
    i_gdr_front_end.set_meas(0, 0, 200, VN, VN, 16'h1388);
    wait_for(2, 1'b1, 60);
    recd[0] <= 1'b1;
    @(posedge clk);
    wait_for(2, 1'b0, 3); hold_low(2, 40);
    bus(1, 8'h68, 32'h1400_1300);
    bus(1, 8'h6C, 1);
    bus(1, 8'h60, 32'h0000_0044);
    hold_low(3, 60);
    ext[1] <= 1'b1;
    wait_for(3, 1'b1, 40);
    decoupling_in[0] <= 1'b1;
    @(posedge clk);
    wait_for(3, 1'b0, 3);
    decoupling_in[0] <= 1'b0;
    trig[1] <= 1'b1;
    hold_low(3, 40);
    trig[1] <= 1'b0;
    bus(1, 8'h64, 32'h0200_0100);
    bus(1, 8'h60, 32'h0000_0084);
    wait_for(3, 1'b1, 40);
    i_gdr_front_end.set_meas(0, 0, 200, VLO, VN, 16'h1388);
    @(posedge clk);
    wait_for(3, 1'b0, 3);
    give_verdict();
  end
endmodule
